// ===== rtl/udt_map.svh
// Register offsets, field positions, reset values and divider counts
// for the up/down reload timer. Included by the timer core and tick
// generator; holds definitions only.
`ifndef UDT_MAP_SVH
`define UDT_MAP_SVH

// ============================================================
// Register byte offsets (low address byte)
`define UDT_CTRL_OFS    8'hC8
`define UDT_MODE_OFS    8'hCC
`define UDT_CNT_OFS     8'hD0
`define UDT_RLD_OFS     8'hD4
`define UDT_STAT_OFS    8'hD8
`define UDT_MASK_OFS    8'hDC

// ============================================================
// timer_control fields
`define UDT_B_OVF       7
`define UDT_B_EXT       6
`define UDT_B_RXSEL     5
`define UDT_B_TXSEL     4
`define UDT_B_EXTEN     3
`define UDT_B_RUN       2
`define UDT_B_SRC       1
`define UDT_B_CRSEL     0

// timer_mode_reg fields
`define UDT_B_CLKOE     1
`define UDT_B_UPDN      0

// Interrupt status / mask fields
`define UDT_I_OVF       0
`define UDT_I_EXT       1

// ============================================================
// Reset values and counts
`define UDT_CTRL_RST    8'h00
`define UDT_MODE_RST    2'h0
`define UDT_CNT_RST     16'h0000
`define UDT_CNT_TOP     16'hFFFF
`define UDT_OSC_DIV     4'hC
`define UDT_OSC_LAST    4'hB
`endif

// ===== rtl/udt_pkg.sv
// Types shared by the up/down reload timer modules.
// Assumes the map header for numeric constants.
package udt_pkg;
  // ============================================================
  // Operating mode, decoded from the serial and capture selects
  typedef enum logic [1:0] {
    UDT_CAPTURE = 2'b00,
    UDT_RELOAD  = 2'b01,
    UDT_BAUD    = 2'b10
  } udt_mode_type;
endpackage

// ===== rtl/udt_tick_if.sv
// Carrier between the timer core and its tick generator.
// Assumes a single hclk domain.
`timescale 1ns/1ps
`default_nettype none
interface udt_tick_if;
  logic run;      // Counting allowed
  logic src_ext;  // Count falling edges of the pin
  logic clk_out;  // Clock-output mode active
  logic pin_in;   // Count pin level
  logic tick;     // One count step this cycle

  modport core (output run, output src_ext, output clk_out, output pin_in, input tick);
  modport gen  (input run, input src_ext, input clk_out, input pin_in, output tick);
endinterface
`default_nettype wire

// ===== rtl/udt_tick_gen.sv
// Tick generator: one-cycle count steps from hclk/12, hclk/2 or
// falling edges on the count pin. Assumes pin is synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "udt_map.svh"
module udt_tick_gen (
  input  wire logic hclk,     // Clock
  input  wire logic hresetn,  // Async reset, active low
  udt_tick_if.gen   tk        // Controls in, tick out
);
  import udt_pkg::*;

  logic [3:0] pre_q;
  logic       half_q;
  logic       pin_q;

  // ============================================================
  // Divide by twelve; free running so run toggles do not skew phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 4'h0;
    end else if (pre_q == `UDT_OSC_LAST) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Half rate for clock-output mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // Previous pin level for falling-edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= tk.pin_in;
    end
  end

  // Source select; nothing advances while stopped
  always_comb begin
    if (!tk.run) begin
      tk.tick = 1'b0;
    end else if (tk.clk_out) begin
      tk.tick = half_q;
    end else if (tk.src_ext) begin
      tk.tick = pin_q & ~tk.pin_in;
    end else begin
      tk.tick = (pre_q == `UDT_OSC_LAST);
    end
  end
endmodule // udt_tick_gen
`default_nettype wire

// ===== rtl/udt_timer.sv
// Up/down auto-reload 16-bit timer with clock output, AHB-Lite slave.
// Assumes hclk is the oscillator and peripheral clock, pins synchronous.
// What this block does
// - Count is one 16-bit value from cascaded low and high bytes.
// - Source select clear counts clock/12 (clock/2 in clock-output mode); set counts count pin falling edges.
// - Low byte advances only while run is set.
// - Capture, auto-reload or baud mode chosen by serial and capture selects.
// - Up/down enable clear counts up; set lets direction pin choose in auto-reload mode.
// - Counting up, overflow past FFFFh sets flag, interrupts, loads reload value (zero in capture mode).
// - Counting down, count equal to reload underflows, sets flag, loads FFFFh.
// - In up/down mode external flag toggles on wrap, without interrupt.
// - Clock-output mode increments at half the clock rate, 50% square wave.
// - Clock-output overflow reloads from reload pair (zero in capture mode); no interrupt.
// - Output frequency is clock over four times (65536 minus reload).
// - Clock output is driven on the count pin in clock-output mode.
// - Baud generation and clock output may run together, sharing reload.
// - Overflow flag set only with both serial selects clear; software clears it.
// - External enable, not baud, not up/down: direction pin falling edge captures or reloads.
// - Each serial select routes overflows out as receive or transmit clock.
`timescale 1ns/1ps
`default_nettype none
`include "udt_map.svh"
module udt_timer (
  input  wire logic        hclk,          // Clock, 125 MHz
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write strobe
  input  wire logic [2:0]  hsize,         // Word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Always ready
  output logic             hresp,         // Always OKAY
  input  wire logic        count_pin_i,   // Count pin level
  output logic             count_pin_o,   // Clock output level
  output logic             count_pin_oe,  // Drive count pin
  input  wire logic        dir_pin,       // Direction control pin
  output logic             rx_baud_tick,  // Receive clock pulse
  output logic             tx_baud_tick,  // Transmit clock pulse
  output logic             irq            // Interrupt, level
);
  import udt_pkg::*;

  // ============================================================
  // State
  logic [7:0]   cnt_lo_q, cnt_hi_q, rld_lo_q, rld_hi_q;
  logic         ovf_q, ext_q, rxsel_q, txsel_q, exten_q;
  logic         run_q, src_q, crsel_q, clkoe_q, updn_q;
  logic [1:0]   stat_q, mask_q;
  logic         pin_o_q, dir_q, rxp_q, txp_q;
  logic         wr_q;
  logic [7:0]   wa_q;
  logic [31:0]  rdata_q;

  logic [15:0]  cnt, rld;
  udt_mode_type mode;
  logic         acc, wr, clk_act, dn, tick;
  logic         wrap_up, wrap_dn, wrap, ext_evt, ovf_set;
  logic         w_ctrl, w_mode, w_cnt, w_rld, w_stat, w_mask;
  logic [31:0]  rd_mux;

  udt_tick_if tk ();

  udt_tick_gen u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk.gen)
  );

  // ============================================================
  // Tick generator controls
  assign clk_act    = clkoe_q & ~src_q;
  assign tk.run     = run_q;
  assign tk.src_ext = src_q;
  assign tk.clk_out = clk_act;
  assign tk.pin_in  = count_pin_i;
  assign tick       = tk.tick;

  // ============================================================
  // Bus slave: zero wait, address latched, write in data phase
  assign acc = hsel & hready & htrans[1];
  assign wr  = wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_q <= acc & hwrite;
      wa_q <= haddr[7:0];
    end
  end

  assign w_ctrl = wr & (wa_q == `UDT_CTRL_OFS);
  assign w_mode = wr & (wa_q == `UDT_MODE_OFS);
  assign w_cnt  = wr & (wa_q == `UDT_CNT_OFS);
  assign w_rld  = wr & (wa_q == `UDT_RLD_OFS);
  assign w_stat = wr & (wa_q == `UDT_STAT_OFS);
  assign w_mask = wr & (wa_q == `UDT_MASK_OFS);

  assign cnt = {cnt_hi_q, cnt_lo_q};
  assign rld = {rld_hi_q, rld_lo_q};

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      `UDT_CTRL_OFS: rd_mux = {24'h00_0000, ovf_q, ext_q, rxsel_q, txsel_q,
                               exten_q, run_q, src_q, crsel_q};
      `UDT_MODE_OFS: rd_mux = {30'h0000_0000, clkoe_q, updn_q};
      `UDT_CNT_OFS:  rd_mux = {16'h0000, cnt};
      `UDT_RLD_OFS:  rd_mux = {16'h0000, rld};
      `UDT_STAT_OFS: rd_mux = {30'h0000_0000, stat_q};
      `UDT_MASK_OFS: rd_mux = {30'h0000_0000, mask_q};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data sampled at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ============================================================
  // Mode decode and wrap detection
  always_comb begin
    if (rxsel_q | txsel_q) begin
      mode = UDT_BAUD;
    end else if (crsel_q) begin
      mode = UDT_CAPTURE;
    end else begin
      mode = UDT_RELOAD;
    end
  end

  // Down only in auto-reload with up/down enabled and pin low
  assign dn      = (mode == UDT_RELOAD) & updn_q & ~dir_pin;
  assign wrap_up = tick & ~dn & (cnt == `UDT_CNT_TOP);
  assign wrap_dn = tick & dn & (cnt == rld);
  assign wrap    = wrap_up | wrap_dn;

  // Pin edge is the direction input in up/down mode, so it is ignored there
  assign ext_evt = dir_q & ~dir_pin & exten_q & (mode != UDT_BAUD)
                   & ~((mode == UDT_RELOAD) & updn_q);

  // Clock output overflows and serial clocking never raise the flag
  assign ovf_set = wrap & (mode != UDT_BAUD) & ~clk_act;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= 1'b1;
    end else begin
      dir_q <= dir_pin;
    end
  end

  // ============================================================
  // Count registers; a software write wins over a count step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cnt_hi_q, cnt_lo_q} <= `UDT_CNT_RST;
    end else if (w_cnt) begin
      {cnt_hi_q, cnt_lo_q} <= hwdata[15:0];
    end else if (wrap_up) begin
      unique case (mode)
        UDT_CAPTURE: {cnt_hi_q, cnt_lo_q} <= `UDT_CNT_RST;
        UDT_RELOAD:  {cnt_hi_q, cnt_lo_q} <= rld;
        UDT_BAUD:    {cnt_hi_q, cnt_lo_q} <= rld;
        default:     {cnt_hi_q, cnt_lo_q} <= rld;
      endcase
    end else if (wrap_dn) begin
      {cnt_hi_q, cnt_lo_q} <= `UDT_CNT_TOP;
    end else if (ext_evt & (mode == UDT_RELOAD)) begin
      {cnt_hi_q, cnt_lo_q} <= rld;
    end else if (tick) begin
      // Low byte carries into high byte through the 16-bit sum
      {cnt_hi_q, cnt_lo_q} <= dn ? cnt - 16'h0001 : cnt + 16'h0001;
    end
  end

  // Reload pair; capture mode copies the count on a pin edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rld_hi_q, rld_lo_q} <= `UDT_CNT_RST;
    end else if (ext_evt & (mode == UDT_CAPTURE)) begin
      {rld_hi_q, rld_lo_q} <= cnt;
    end else if (w_rld) begin
      {rld_hi_q, rld_lo_q} <= hwdata[15:0];
    end
  end

  // ============================================================
  // Control and mode registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rxsel_q, txsel_q, exten_q, run_q, src_q, crsel_q} <= 6'(`UDT_CTRL_RST);
      {clkoe_q, updn_q} <= `UDT_MODE_RST;
    end else begin
      if (w_ctrl) begin
        rxsel_q <= hwdata[`UDT_B_RXSEL];
        txsel_q <= hwdata[`UDT_B_TXSEL];
        exten_q <= hwdata[`UDT_B_EXTEN];
        run_q   <= hwdata[`UDT_B_RUN];
        src_q   <= hwdata[`UDT_B_SRC];
        crsel_q <= hwdata[`UDT_B_CRSEL];
      end
      if (w_mode) begin
        clkoe_q <= hwdata[`UDT_B_CLKOE];
        updn_q  <= hwdata[`UDT_B_UPDN];
      end
    end
  end

  // Overflow flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1;
    end else if (w_ctrl) begin
      ovf_q <= hwdata[`UDT_B_OVF];
    end
  end

  // External flag: toggles as a 17th bit in up/down mode, else set on edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else if (wrap & (mode == UDT_RELOAD) & updn_q) begin
      ext_q <= ~(w_ctrl ? hwdata[`UDT_B_EXT] : ext_q);
    end else if (ext_evt) begin
      ext_q <= 1'b1;
    end else if (w_ctrl) begin
      ext_q <= hwdata[`UDT_B_EXT];
    end
  end

  // ============================================================
  // Interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q[`UDT_I_OVF] <= ovf_set |
        (stat_q[`UDT_I_OVF] & ~(w_stat & hwdata[`UDT_I_OVF]));
      // The up/down toggle is left out on purpose: it never interrupts
      stat_q[`UDT_I_EXT] <= ext_evt |
        (stat_q[`UDT_I_EXT] & ~(w_stat & hwdata[`UDT_I_EXT]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= 2'h0;
    end else if (w_mask) begin
      mask_q <= hwdata[1:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // ============================================================
  // Clock output: pin toggles per overflow, half period (65536-R)*2 cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o_q <= 1'b0;
    end else if (wrap_up & clk_act) begin
      pin_o_q <= ~pin_o_q;
    end
  end

  assign count_pin_o  = pin_o_q;
  assign count_pin_oe = clk_act;

  // ============================================================
  // Serial clock pulses, one cycle after the overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxp_q <= 1'b0;
      txp_q <= 1'b0;
    end else begin
      rxp_q <= wrap_up & rxsel_q;
      txp_q <= wrap_up & txsel_q;
    end
  end

  assign rx_baud_tick = rxp_q;
  assign tx_baud_tick = txp_q;
endmodule // udt_timer
`default_nettype wire

// ===== tb/udt_timer_sva.sv
// Port checker for the up/down reload timer.
// Assumes one hclk domain; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module udt_timer_sva (
  input wire logic        hclk,          // Clock
  input wire logic        hresetn,       // Reset, active low
  input wire logic [31:0] hrdata,        // Read data
  input wire logic        hreadyout,     // Ready
  input wire logic        hresp,         // Response
  input wire logic        count_pin_o,   // Clock output level
  input wire logic        count_pin_oe,  // Pin drive enable
  input wire logic        rx_baud_tick,  // Receive tick
  input wire logic        tx_baud_tick,  // Transmit tick
  input wire logic        irq            // Interrupt
);
  // ============================================================
  // Bus, pin and tick relations
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_zero_wait:
    assert property (hreadyout) else $error("ready went low");
  chk_resp_okay:
    assert property (!hresp) else $error("error response");
  chk_upper_zero:
    assert property (hrdata[31:16] == 16'h0000) else $error("upper read bits set");
  chk_half_min:
    assert property ($changed(count_pin_o) |=> $stable(count_pin_o)) else $error("output toggled twice");
  chk_out_needs_oe:
    assert property ($changed(count_pin_o) |-> $past(count_pin_oe)) else $error("toggle while not driving");
  chk_off_steady:
    assert property (!count_pin_oe [*2] |-> $stable(count_pin_o)) else $error("output moved while off");
  chk_rx_pulse:
    assert property (rx_baud_tick |=> !rx_baud_tick) else $error("receive tick too long");
  chk_tx_pulse:
    assert property (tx_baud_tick |=> !tx_baud_tick) else $error("transmit tick too long");
  // Main scenarios reached
  cover property ($rose(count_pin_o));
  cover property (tx_baud_tick);
  cover property ($rose(irq));
endmodule // udt_timer_sva
bind udt_timer udt_timer_sva u_sva (.hclk, .hresetn, .hrdata, .hreadyout, .hresp, .count_pin_o,
  .count_pin_oe, .rx_baud_tick, .tx_baud_tick, .irq);
`default_nettype wire

// ===== tb/udt_pins_model.sv
// Model of the count and direction pins outside the timer.
// Assumes pins synchronous to hclk; the count pin has no pull.
`timescale 1ns/1ps
`default_nettype none
module udt_pins_model (
  input  wire logic hclk,          // Clock
  input  wire logic count_pin_o,   // Timer clock output
  input  wire logic count_pin_oe,  // Timer drives the pin
  output logic      count_pin_i,   // Resolved pin level
  output logic      dir_pin        // Direction control level
);
  logic drv = 1'b1;  // Outside source level
  // ============================================================
  // The outside source lets go while the timer drives
  assign count_pin_i = count_pin_oe ? count_pin_o : drv;
  initial dir_pin = 1'b1;
  // Falling edges, two cycles a level so none is missed
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge hclk);
      drv <= 1'b0;
      repeat (2) @(posedge hclk);
      drv <= 1'b1;
      @(posedge hclk);
    end
  endtask
  // Direction level; a fall is also the external event
  task automatic set_dir(input logic v);
    @(posedge hclk);
    dir_pin <= v;
  endtask
endmodule // udt_pins_model
`default_nettype wire

// ===== tb/udt_timer_tb.sv
// Self-checking bench for the up/down reload timer.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "udt_map.svh"
module udt_timer_tb;
  import udt_pkg::*;
  localparam logic [7:0] RL  = 8'h00;  // Capture/reload select clear picks auto-reload
  localparam logic [7:0] CT = `UDT_CTRL_OFS, MD = `UDT_MODE_OFS, CN = `UDT_CNT_OFS;
  localparam logic [7:0] RD = `UDT_RLD_OFS, ST = `UDT_STAT_OFS, MK = `UDT_MASK_OFS;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, rv;
  logic        hready, hresp, pin_i, pin_o, pin_oe, dir, rxt, txt, irq, up;
  logic [15:0] r, c, e;
  logic [7:0]  cv;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          n, k, w, nr, nt;
  logic [7:0]  ofs [7] = '{CT, MD, CN, RD, ST, MK, 8'hE0};
  // 125 MHz clock
  always #4 hclk = ~hclk;
  udt_timer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout(hready), .hresp, .count_pin_i(pin_i), .count_pin_o(pin_o),
    .count_pin_oe(pin_oe), .dir_pin(dir), .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq);
  udt_pins_model pm (.hclk, .count_pin_o(pin_o), .count_pin_oe(pin_oe), .count_pin_i(pin_i),
    .dir_pin(dir));
  // ============================================================
  // Bus cycles; each holds until ready is seen high
  task automatic bus(input logic [7:0] a, input logic wr_en, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr_en;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, rv);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, rv);
    chk(rv, exp);
  endtask
  // Cycles until the clock output changes level, bounded
  task automatic flip(output int cyc);
    logic v;
    v   = pin_o;
    cyc = 0;
    do begin
      @(posedge hclk);
      cyc++;
    end while (pin_o === v && cyc < 300);
  endtask
  // One count step: wrap up to reload, down to all ones
  function automatic logic [15:0] step(input logic [15:0] x, input logic [15:0] rl, input logic u);
    if (u) return (x == 16'hFFFF) ? rl : x + 16'h0001;
    return (x == rl) ? 16'hFFFF : x - 16'h0001;
  endfunction
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(17821));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(32'(pin_oe), 32'h0);
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    r = 16'($urandom());
    wr(RD, 32'(r));
    rdc(RD, 32'(r));
    // Pin counting both ways; the first pass leaves run clear
    for (int i = 0; i < 12; i++) begin
      r  = 16'($urandom()) & 16'h7FFF;
      up = i[0];
      k  = $urandom_range(3, 0);
      n  = $urandom_range(6, 1);
      c  = up ? 16'hFFFF - 16'(k) : r + 16'(k);
      cv = RL | ((i > 0) ? 8'h06 : 8'h02);
      pm.set_dir(up);
      wr(MD, 32'h1);
      wr(MK, 32'(i[1]));
      wr(RD, 32'(r));
      wr(CN, 32'(c));
      wr(CT, 32'(cv));
      pm.edges(n);
      e = c;
      w = 0;
      repeat ((i > 0) ? n : 0) begin
        w += ((up && e == 16'hFFFF) || (!up && e == r)) ? 1 : 0;
        e = step(e, r, up);
      end
      repeat (2) @(posedge hclk);
      rdc(CN, 32'(e));
      rdc(ST, 32'(w > 0));
      chk(32'(irq), 32'(w > 0 && i[1]));
      rdc(CT, {24'h0, w > 0, w[0], 6'h00} | 32'(cv));
      wr(CT, 32'h0);
      wr(ST, 32'h3);
      rdc(ST, 32'h0);
    end
    // Falling edge on the direction pin reloads the count
    wr(MD, 32'h0);
    wr(RD, 32'h1234);
    wr(CN, 32'h0042);
    wr(MK, 32'h2);
    pm.set_dir(1'b1);
    wr(CT, 32'(RL | 8'h08));
    pm.set_dir(1'b0);
    repeat (3) @(posedge hclk);
    rdc(CN, 32'h1234);
    rdc(ST, 32'h2);
    chk(32'(irq), 32'h1);
    rdc(CT, 32'(RL | 8'h48));
    wr(CT, 32'h0);
    wr(ST, 32'h3);
    // Capture mode: a direction pin fall copies the count into reload
    pm.set_dir(1'b1);
    wr(CN, 32'h0055);
    wr(CT, 32'h09);
    pm.set_dir(1'b0);
    repeat (3) @(posedge hclk);
    rdc(RD, 32'h0055);
    rdc(CT, 32'h49);
    wr(CT, 32'h0);
    wr(ST, 32'h3);
    // Internal clock over twelve: ten or eleven steps in 122 cycles
    wr(CN, 32'h0);
    wr(CT, 32'(RL | 8'h04));
    repeat (120) @(posedge hclk);
    wr(CT, 32'(RL));
    bus(CN, 1'b0, 32'h0, rv);
    chk(32'(rv >= 32'hA && rv <= 32'hB), 32'h1);
    // Clock output set up in order, with both serial selects on
    wr(MK, 32'h3);
    wr(MD, 32'h2);
    wr(CT, 32'(RL));
    wr(RD, 32'hFFF0);
    wr(CN, 32'hFFF0);
    wr(CT, 32'(RL | 8'h34));
    chk(32'(pin_oe), 32'h1);
    flip(k);
    flip(k);
    chk(k, 32);
    nr = 0;
    nt = 0;
    repeat (96) begin
      @(posedge hclk);
      nr += int'(rxt);
      nt += int'(txt);
    end
    chk(nr, 3);
    chk(nt, 3);
    wr(CT, 32'(RL));
    rdc(ST, 32'h0);
    chk(32'(irq), 32'h0);
    // Clock output alone: overflows reload but raise no flag
    wr(CT, 32'(RL | 8'h04));
    repeat (70) @(posedge hclk);
    wr(CT, 32'(RL));
    rdc(ST, 32'h0);
    rdc(CT, 32'(RL));
    chk(32'(irq), 32'h0);
    wr(MD, 32'h0);
    @(posedge hclk);
    chk(32'(pin_oe), 32'h0);
    give_verdict();
  end
  // Watchdog: the sequence needs well under 20000 cycles
  initial begin
    #(8 * 20000);
    mismatches++;
    give_verdict();
  end
endmodule // udt_timer_tb
`default_nettype wire
